/* File: parallel_io_ports_tb.sv */
`timescale 1ns/1ps
module parallel_io_ports_tb;
	localparam int PG = 4;
	localparam int PH = 4;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [7:0][7:0] pin_in;
	logic [7:0][7:0] pin_out;
	logic [7:0][7:0] pin_oe;
	logic [7:0][7:0] ext_val = {8{8'h5A}};
	logic [31:0] rd;
	logic er;
	int err_count = 0;
	int n_checks = 0;
	int cyc = 0;

	always #25 clk = ~clk;

	pio_ports #(.ADDR_W(12), .PORT_F_WIDTH(6), .PORT_G_WIDTH(PG), .PORT_H_WIDTH(PH)) dut (
		.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));

	pio_pins_model pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val), .pin_in(pin_in));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// hang guard, far above the few hundred cycles the tests need
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			err_count++;
			$display("[FAIL] %0t timeout", $time);
			complete_run();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	// one apb transfer; waits for pready without assuming a latency
	task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] wd);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h000000, wd};
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk({31'h0, n < 20}, 32'h1, "pready wait");
	endtask

	task automatic rchk(input logic [11:0] a, input logic [7:0] e, input logic ee);
		apb(1'b0, a, 8'h00);
		chk(rd, {24'h000000, e}, "read data");
		chk({31'h0, er}, {31'h0, ee}, "slave error");
	endtask

	// byte address of a port's data or direction register
	function automatic logic [11:0] adr(input int p, input logic d);
		int i;
		i = (p < 4) ? p + (d ? 4 : 0) : p + 4 + (d ? 4 : 0);
		return 12'(i * 4);
	endfunction

	function automatic logic [7:0] msk(input int p);
		int w;
		w = (p == 5) ? 6 : (p == 6) ? PG : (p == 7) ? PH : 8;
		return 8'((1 << w) - 1);
	endfunction

	task automatic rst3();
		nrst <= 1'b0;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
	endtask

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		rst3();
		for (int p = 0; p < 8; p++) begin
			rchk(adr(p, 1'b1), 8'h00, 1'b0);
		end
		chk({31'h0, pin_oe != '0}, 32'h0, "oe after reset");
		$display("done: reset values");
		// latch written while the pin is an input, read still shows the pin
		for (int p = 0; p < 8; p++) begin
			apb(1'b1, adr(p, 1'b0), 8'hC3);
			rchk(adr(p, 1'b0), 8'h5A & msk(p), 1'b0);
		end
		$display("done: input reads");
		// data already loaded, now turn every pin to output
		for (int p = 0; p < 8; p++) begin
			apb(1'b1, adr(p, 1'b1), 8'hFF);
			rchk(adr(p, 1'b0), 8'hC3 & msk(p), 1'b0);
			rchk(adr(p, 1'b1), msk(p), 1'b0);
			chk(32'(pin_oe[p]), 32'(msk(p)), "oe on");
			chk(32'(pin_out[p]), 32'(8'hC3 & msk(p)), "latch out");
			chk(32'(pin_in[p] & msk(p)), 32'(8'hC3 & msk(p)), "pin level");
		end
		$display("done: output reads");
		// mixed direction on port B with a new outside level
		apb(1'b1, adr(1, 1'b1), 8'h0F);
		ext_val[1] <= 8'h96;
		repeat (4) @(posedge clk);
		rchk(adr(1, 1'b0), 8'h93, 1'b0);
		chk(32'(pin_oe[1]), 32'h0F, "oe mixed");
		chk(32'(pin_oe[0]), 32'hFF, "oe neighbour");
		// data write while port C drives, read back from the latch
		apb(1'b1, adr(2, 1'b0), 8'h3C);
		rchk(adr(2, 1'b0), 8'h3C, 1'b0);
		$display("done: mixed direction");
		// refused accesses: beyond the map and misaligned
		rchk(12'h040, 8'h00, 1'b1);
		apb(1'b1, 12'h002, 8'h00);
		chk({31'h0, er}, 32'h1, "misaligned write");
		rchk(12'h001, 8'h00, 1'b1);
		rchk(adr(0, 1'b0), 8'hC3, 1'b0);
		$display("done: refused accesses");
		// reset in mid-run clears direction, keeps the latches
		rst3();
		rchk(adr(0, 1'b1), 8'h00, 1'b0);
		rchk(adr(0, 1'b0), 8'h5A, 1'b0);
		apb(1'b1, adr(0, 1'b1), 8'hFF);
		rchk(adr(0, 1'b0), 8'hC3, 1'b0);
		$display("done: second reset");
		complete_run();
	end
endmodule

/* File: pio_pins_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// external circuits on the two-way pins
// ----------------------------------------------------------------
module pio_pins_model (
	input wire logic [pio_pkg::NUM_PORTS-1:0][pio_pkg::PORT_W-1:0] pin_out,
	input wire logic [pio_pkg::NUM_PORTS-1:0][pio_pkg::PORT_W-1:0] pin_oe,
	input wire logic [pio_pkg::NUM_PORTS-1:0][pio_pkg::PORT_W-1:0] ext_val,
	output logic [pio_pkg::NUM_PORTS-1:0][pio_pkg::PORT_W-1:0] pin_in
);
	// wire level: a driving device wins, the outside circuit yields to it
	// the outside always drives undriven pins, so an input never floats to x
	always_comb begin
		pin_in = (pin_oe & pin_out) | (~pin_oe & ext_val);
	end
endmodule

/* File: pio_pkg.sv */
package pio_pkg;

	// ----------------------------------------------------------------
	// geometry of the port bank and of the bus
	// ----------------------------------------------------------------
	localparam int NUM_PORTS = 8;
	localparam int PORT_W = 8;
	localparam int APB_DATA_W = 32;
	localparam int PINS_TOTAL = 54;
	localparam int IDX_LSB = 2;
	localparam int IDX_MSB = 5;

	// ----------------------------------------------------------------
	// register indexes, byte address is four times the index
	// ----------------------------------------------------------------
	localparam logic [3:0] IDX_PORT_A_DATA = 4'h0;
	localparam logic [3:0] IDX_PORT_B_DATA = 4'h1;
	localparam logic [3:0] IDX_PORT_C_DATA = 4'h2;
	localparam logic [3:0] IDX_PORT_D_DATA = 4'h3;
	localparam logic [3:0] IDX_PORT_A_DIRECTION = 4'h4;
	localparam logic [3:0] IDX_PORT_B_DIRECTION = 4'h5;
	localparam logic [3:0] IDX_PORT_C_DIRECTION = 4'h6;
	localparam logic [3:0] IDX_PORT_D_DIRECTION = 4'h7;
	localparam logic [3:0] IDX_PORT_E_DATA = 4'h8;
	localparam logic [3:0] IDX_PORT_F_DATA = 4'h9;
	localparam logic [3:0] IDX_PORT_G_DATA = 4'hA;
	localparam logic [3:0] IDX_PORT_H_DATA = 4'hB;
	localparam logic [3:0] IDX_PORT_E_DIRECTION = 4'hC;
	localparam logic [3:0] IDX_PORT_F_DIRECTION = 4'hD;
	localparam logic [3:0] IDX_PORT_G_DIRECTION = 4'hE;
	localparam logic [3:0] IDX_PORT_H_DIRECTION = 4'hF;

	// ----------------------------------------------------------------
	// reset and idle values
	// ----------------------------------------------------------------
	localparam logic [7:0] DIR_RESET = 8'h00;
	localparam logic [7:0] FULL_MASK = 8'hFF;
	localparam logic [31:0] RDATA_IDLE = 32'h00000000;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		PORT_A, PORT_B, PORT_C, PORT_D, PORT_E, PORT_F, PORT_G, PORT_H
	} pio_port_t;

	// decoded register selection
	typedef struct packed {
		logic hit;
		logic is_dir;
		pio_port_t port;
	} pio_sel_t;

endpackage

/* File: pio_ports.sv */
`timescale 1ns/1ps
module pio_ports #(
	parameter int ADDR_W = 12,
	parameter int PORT_F_WIDTH = 6,
	parameter int PORT_G_WIDTH = 4,
	parameter int PORT_H_WIDTH = 4
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [pio_pkg::NUM_PORTS-1:0][pio_pkg::PORT_W-1:0] pin_in,
	output wire logic [pio_pkg::NUM_PORTS-1:0][pio_pkg::PORT_W-1:0] pin_out,
	output logic [pio_pkg::NUM_PORTS-1:0][pio_pkg::PORT_W-1:0] pin_oe
);

	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	// the bank must add up to its pin count and each port fit a byte
	if (5 * pio_pkg::PORT_W + PORT_F_WIDTH + PORT_G_WIDTH + PORT_H_WIDTH
		!= pio_pkg::PINS_TOTAL) begin : g_bad_count
		$error("port widths do not add up to the pin count");
	end
	if (PORT_G_WIDTH < 1 || PORT_G_WIDTH > pio_pkg::PORT_W ||
		PORT_H_WIDTH < 1 || PORT_H_WIDTH > pio_pkg::PORT_W ||
		PORT_F_WIDTH < 1 || PORT_F_WIDTH >= pio_pkg::PORT_W) begin : g_bad_width
		// port F must leave at least one bit that reads as zero
		$error("a port width is out of range");
	end
	if (ADDR_W < pio_pkg::IDX_MSB + 1) begin : g_bad_addr
		$error("address too narrow for the register map");
	end

	// ----------------------------------------------------------------
	// helper functions
	// ----------------------------------------------------------------
	// implemented pins of a port of the given width, from bit 0 upward
	function automatic logic [pio_pkg::PORT_W-1:0] width_mask(input int w);
		logic [pio_pkg::PORT_W-1:0] m;
		m = '0;
		for (int i = 0; i < pio_pkg::PORT_W; i++) begin
			if (i < w) begin
				m[i] = 1'b1;
			end
		end
		return m;
	endfunction

	function automatic pio_pkg::pio_sel_t mk_sel(input logic is_dir,
		input pio_pkg::pio_port_t port);
		pio_pkg::pio_sel_t s;
		s.hit = 1'b1;
		s.is_dir = is_dir;
		s.port = port;
		return s;
	endfunction

	// byte address to register; misaligned or out of range is a miss
	function automatic pio_pkg::pio_sel_t decode(input logic [ADDR_W-1:0] a);
		pio_pkg::pio_sel_t s;
		s = '0;
		unique case (a[pio_pkg::IDX_MSB:pio_pkg::IDX_LSB])
			pio_pkg::IDX_PORT_A_DATA: s = mk_sel(1'b0, pio_pkg::PORT_A);
			pio_pkg::IDX_PORT_B_DATA: s = mk_sel(1'b0, pio_pkg::PORT_B);
			pio_pkg::IDX_PORT_C_DATA: s = mk_sel(1'b0, pio_pkg::PORT_C);
			pio_pkg::IDX_PORT_D_DATA: s = mk_sel(1'b0, pio_pkg::PORT_D);
			pio_pkg::IDX_PORT_A_DIRECTION: s = mk_sel(1'b1, pio_pkg::PORT_A);
			pio_pkg::IDX_PORT_B_DIRECTION: s = mk_sel(1'b1, pio_pkg::PORT_B);
			pio_pkg::IDX_PORT_C_DIRECTION: s = mk_sel(1'b1, pio_pkg::PORT_C);
			pio_pkg::IDX_PORT_D_DIRECTION: s = mk_sel(1'b1, pio_pkg::PORT_D);
			pio_pkg::IDX_PORT_E_DATA: s = mk_sel(1'b0, pio_pkg::PORT_E);
			pio_pkg::IDX_PORT_F_DATA: s = mk_sel(1'b0, pio_pkg::PORT_F);
			pio_pkg::IDX_PORT_G_DATA: s = mk_sel(1'b0, pio_pkg::PORT_G);
			pio_pkg::IDX_PORT_H_DATA: s = mk_sel(1'b0, pio_pkg::PORT_H);
			pio_pkg::IDX_PORT_E_DIRECTION: s = mk_sel(1'b1, pio_pkg::PORT_E);
			pio_pkg::IDX_PORT_F_DIRECTION: s = mk_sel(1'b1, pio_pkg::PORT_F);
			pio_pkg::IDX_PORT_G_DIRECTION: s = mk_sel(1'b1, pio_pkg::PORT_G);
			pio_pkg::IDX_PORT_H_DIRECTION: s = mk_sel(1'b1, pio_pkg::PORT_H);
		endcase
		if (a[pio_pkg::IDX_LSB-1:0] != '0) begin
			s.hit = 1'b0;
		end
		if (ADDR_W > pio_pkg::IDX_MSB + 1) begin
			if ((a >> (pio_pkg::IDX_MSB + 1)) != '0) begin
				s.hit = 1'b0;
			end
		end
		return s;
	endfunction

	// per-bit choice between latch and pin, unimplemented bits as zero
	function automatic logic [pio_pkg::PORT_W-1:0] rd_port(
		input logic [pio_pkg::PORT_W-1:0] latch,
		input logic [pio_pkg::PORT_W-1:0] dir,
		input logic [pio_pkg::PORT_W-1:0] pin,
		input logic [pio_pkg::PORT_W-1:0] mask);
		return ((dir & latch) | (~dir & pin)) & mask;
	endfunction

	// ----------------------------------------------------------------
	// implemented pin masks
	// ----------------------------------------------------------------
	// ports A to E are full bytes; F is narrower, G and H up to a full byte each
	localparam logic [pio_pkg::NUM_PORTS-1:0][pio_pkg::PORT_W-1:0] IMPL = {
		width_mask(PORT_H_WIDTH), width_mask(PORT_G_WIDTH),
		width_mask(PORT_F_WIDTH), {5{pio_pkg::FULL_MASK}}};

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	pio_pkg::pio_sel_t sel;
	logic access;
	logic wr_fire;
	logic [pio_pkg::PORT_W-1:0] wbyte;

	// two-cycle access: pready rises one edge into the access phase
	assign sel = decode(paddr);
	assign access = psel & penable;
	assign wr_fire = access & pready & pwrite & sel.hit;
	assign wbyte = pwdata[pio_pkg::PORT_W-1:0];

	// ----------------------------------------------------------------
	// pin input synchroniser
	// ----------------------------------------------------------------
	logic [pio_pkg::NUM_PORTS-1:0][pio_pkg::PORT_W-1:0] pin_meta_r;
	logic [pio_pkg::NUM_PORTS-1:0][pio_pkg::PORT_W-1:0] pin_sync_r;

	// two stages, only the second feeds the read path
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pin_meta_r <= '0;
			pin_sync_r <= '0;
		end else begin
			pin_meta_r <= pin_in;
			pin_sync_r <= pin_meta_r;
		end
	end

	// ----------------------------------------------------------------
	// direction registers
	// ----------------------------------------------------------------
	// drive enables come straight from these flops
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pin_oe <= {pio_pkg::NUM_PORTS{pio_pkg::DIR_RESET}};
		end else if (wr_fire && sel.is_dir) begin
			pin_oe[sel.port] <= wbyte & IMPL[sel.port];
		end
	end

	// ----------------------------------------------------------------
	// data latches
	// ----------------------------------------------------------------
	// no reset on purpose: the latch keeps its value through reset
	for (genvar p = 0; p < pio_pkg::NUM_PORTS; p++) begin : g_latch
		logic [pio_pkg::PORT_W-1:0] latch_r;

		// written whatever the direction bit says
		always_ff @(posedge clk) begin
			if (wr_fire && !sel.is_dir && sel.port == pio_pkg::pio_port_t'(p)) begin
				latch_r <= wbyte & IMPL[p];
			end
		end

		// absent bits dropped on write, so the pin sees the flop itself
		assign pin_out[p] = latch_r;
	end

	// ----------------------------------------------------------------
	// read data and handshake
	// ----------------------------------------------------------------
	// answer one edge into the access phase, then drop for one cycle
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= pio_pkg::RDATA_IDLE;
		end else if (access && !pready) begin
			pready <= 1'b1;
			pslverr <= ~sel.hit;
			prdata <= pio_pkg::RDATA_IDLE;
			if (!pwrite && sel.hit) begin
				if (sel.is_dir) begin
					prdata <= 32'(pin_oe[sel.port]);
				end else begin
					prdata <= 32'(rd_port(pin_out[sel.port], pin_oe[sel.port],
						pin_sync_r[sel.port], IMPL[sel.port]));
				end
			end
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= pio_pkg::RDATA_IDLE;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	logic rd_ans;
	assign rd_ans = access & !pready & !pwrite & sel.hit & !sel.is_dir;

	property p_dir_reset;
		@(posedge clk) $rose(nrst) |-> pin_oe == '0;
	endproperty
	a_dir_reset: assert property (p_dir_reset)
		else $error("direction not clear after reset");

	property p_absent_pins;
		@(posedge clk) disable iff (!nrst)
		((pin_oe[pio_pkg::PORT_F] & ~IMPL[pio_pkg::PORT_F]) == '0) &&
		((pin_out[pio_pkg::PORT_F] & ~IMPL[pio_pkg::PORT_F]) == '0);
	endproperty
	a_absent_pins: assert property (p_absent_pins)
		else $error("unimplemented port F pin driven");

	property p_dir_write;
		@(posedge clk) disable iff (!nrst)
		(wr_fire && sel.is_dir && sel.port == pio_pkg::PORT_A) |=>
		pin_oe[pio_pkg::PORT_A] == $past(wbyte);
	endproperty
	a_dir_write: assert property (p_dir_write)
		else $error("port A direction write lost");

	property p_dir_local;
		@(posedge clk) disable iff (!nrst)
		(wr_fire && sel.is_dir && sel.port == pio_pkg::PORT_B) |=>
		$stable(pin_oe[pio_pkg::PORT_A]) && $stable(pin_oe[pio_pkg::PORT_C]);
	endproperty
	a_dir_local: assert property (p_dir_local)
		else $error("direction write touched another port");

	property p_f_top_zero;
		@(posedge clk) disable iff (!nrst)
		(access && !pready && !pwrite && paddr == ADDR_W'(4 * pio_pkg::IDX_PORT_F_DATA))
		##1 pready |-> prdata[pio_pkg::PORT_W-1:PORT_F_WIDTH] == '0;
	endproperty
	a_f_top_zero: assert property (p_f_top_zero)
		else $error("port F upper bits not zero");

	property p_read_mux;
		@(posedge clk) disable iff (!nrst)
		(rd_ans && sel.port == pio_pkg::PORT_A) |=>
		prdata[pio_pkg::PORT_W-1:0] ==
		(($past(pin_oe[pio_pkg::PORT_A]) & $past(pin_out[pio_pkg::PORT_A])) |
		(~$past(pin_oe[pio_pkg::PORT_A]) & $past(pin_sync_r[pio_pkg::PORT_A])));
	endproperty
	a_read_mux: assert property (p_read_mux)
		else $error("port A read returned wrong source");

	property p_latch_write;
		@(posedge clk) disable iff (!nrst)
		(wr_fire && !sel.is_dir && sel.port == pio_pkg::PORT_B) |=>
		pin_out[pio_pkg::PORT_B] == $past(wbyte) && $stable(pin_oe[pio_pkg::PORT_B]);
	endproperty
	a_latch_write: assert property (p_latch_write)
		else $error("port B latch write lost");

	property p_write_edge;
		@(posedge clk) disable iff (!nrst)
		!$past(wr_fire) |-> $stable(pin_out) && $stable(pin_oe);
	endproperty
	a_write_edge: assert property (p_write_edge)
		else $error("register changed outside a closing write edge");

	property p_oe_drives_latch;
		@(posedge clk) disable iff (!nrst)
		(wr_fire && !sel.is_dir && sel.port == pio_pkg::PORT_C) ##1
		pin_oe[pio_pkg::PORT_C][0] |-> pin_out[pio_pkg::PORT_C][0] == $past(wbyte[0]);
	endproperty
	a_oe_drives_latch: assert property (p_oe_drives_latch)
		else $error("output pin not driving the latch");

	property p_sync_delay;
		@(posedge clk) disable iff (!nrst)
		nrst ##1 nrst ##1 nrst |-> pin_sync_r == $past(pin_in, 2);
	endproperty
	a_sync_delay: assert property (p_sync_delay)
		else $error("pin sample not two cycles late");

	property p_latch_keeps;
		@(posedge clk)
		$rose(nrst) |-> $stable(pin_out);
	endproperty
	a_latch_keeps: assert property (p_latch_keeps)
		else $error("latch changed across reset");

	property p_answer_once;
		@(posedge clk) disable iff (!nrst)
		pready |=> !pready;
	endproperty
	a_answer_once: assert property (p_answer_once)
		else $error("pready held for two cycles");

	property p_refused;
		@(posedge clk) disable iff (!nrst)
		(access && !pready && !sel.hit) |=> pready && pslverr && prdata == '0;
	endproperty
	a_refused: assert property (p_refused)
		else $error("unmapped access not refused");

	property p_quiet_idle;
		@(posedge clk) disable iff (!nrst)
		!pready |-> prdata == '0 && !pslverr;
	endproperty
	a_quiet_idle: assert property (p_quiet_idle)
		else $error("read data or error outside the answer cycle");

	property p_dir_read;
		@(posedge clk) disable iff (!nrst)
		(access && !pready && !pwrite && sel.hit && sel.is_dir && sel.port == pio_pkg::PORT_B)
		|=> prdata == 32'($past(pin_oe[pio_pkg::PORT_B]));
	endproperty
	a_dir_read: assert property (p_dir_read)
		else $error("port B direction read wrong");

	property p_refused_write;
		@(posedge clk) disable iff (!nrst)
		(access && pready && pwrite && !sel.hit) |=> $stable(pin_oe) && $stable(pin_out);
	endproperty
	a_refused_write: assert property (p_refused_write)
		else $error("refused write changed a register");

	property p_f_dir_mask;
		@(posedge clk) disable iff (!nrst)
		(wr_fire && sel.is_dir && sel.port == pio_pkg::PORT_F) |=>
		pin_oe[pio_pkg::PORT_F] == ($past(wbyte) & IMPL[pio_pkg::PORT_F]);
	endproperty
	a_f_dir_mask: assert property (p_f_dir_mask)
		else $error("port F direction write not masked to its pins");

endmodule
